/* File: svl_rx_pkg.sv */
// constants, field layout and state encoding of the serial video link receiver
// assumes a one-bit-per-edge link clock and a single core clock on the output side
package svl_rx_pkg;
  // link frame, oldest bit at the top of the shift register
  localparam int FRAME_BITS = 28;
  localparam logic [4:0] FRAME_LAST = 5'h1b;
  localparam int POS_START = 27;
  localparam int POS_INV = 26;
  localparam int POS_DATA_HI = 25;
  localparam int POS_DATA_LO = 2;
  localparam int POS_PAD = 1;
  localparam int POS_STOP = 0;
  localparam logic [2:0] LOCK_LAST = 3'h3;
  // pixel word layout
  localparam int PIX_W = 24;
  localparam int PIX_LAST = 20;
  localparam int HS_BIT = 18;
  localparam int VS_BIT = 19;
  localparam int DE_BIT = 20;
  localparam int OS_LO = 21;
  localparam int OS_HI = 23;
  localparam int FIFO_DEPTH = 8;
  // output lanes, seven bits per pixel on each lane
  localparam int LANES = 3;
  localparam int LANE_BITS = 7;
  localparam logic [2:0] LANE_LAST = 3'h6;
  localparam logic [6:0] CLK_PATTERN = 7'h63;
  // supported pixel clock band in MHz
  localparam int PIX_MIN_MHZ = 5;
  localparam int PIX_MAX_MHZ = 43;
  localparam int LF_MAX_MHZ = 20;
  localparam int OS_RATE_DIV = 5;
  // pin synchroniser bit positions
  localparam int SY_LOCK = 0;
  localparam int SY_PD = 1;
  localparam int SY_OE = 2;
  localparam int SY_LF = 3;
  localparam int SY_OSS = 4;
  localparam int SY_W = 5;
  // values after reset
  localparam logic [2:0] LANE_IDLE = 3'h0;
  localparam logic [2:0] OS_RST = 3'h0;
  localparam logic LF_RST = 1'b0;
  localparam logic OSS_RST = 1'b0;
  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_VERIFY = 2'b01,
    ST_LOCKED = 2'b11
  } linkState_t;
endpackage

/* File: serial_video_link_receiver.sv */
// serial video link receiver: frame lock, balance decode, word fifo, lane serialiser
// assumes serialBitClk delivers one line bit per rising edge and core_clk is unrelated
// Summary of operation
// - locked flag high while frame recovery is locked; lanes then carry pixels
// - unlocked: locked flag low, lanes idle low, slow bits take the sleep state chosen by select
// - power-down-bar high: receive, decode and forward the stream normally
// - power-down-bar low: locked flag, lanes, slow bits and band flag low, configuration back to reset
// - lane enable high drives the lanes, low releases them
// - slow bits 0,1,2 come from upstream word bits 21,22,23
// - lock is found on any data, no training pattern or reference clock
// - balance-coded payload is inverted back when its invert flag is set
// - each pixel yields 6-bit red, green, blue plus vs, hs, de
// - pixels leave on three serial data lanes with one clock lane
// - link covers pixel rates from 5 to 43 MHz
// - low-frequency select high picks the 5-20 MHz band, low 20-43 MHz
`timescale 1ns/100ps

module svl_word_fifo
  import svl_rx_pkg::*;
#(
  parameter int WIDTH = PIX_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic reset_n,
  input wire logic wrClk,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdClk,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  // depth must be a power of two for the gray pointers
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] rgS1;
    logic [AW:0] rgS2;
  } wside_t;
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] wgS1;
    logic [AW:0] wgS2;
  } rside_t;
  wside_t w, wn;
  rside_t r, rn;
  logic full;
  logic empty;
  logic [AW:0] wBinNxt;
  logic [AW:0] rBinNxt;

  assign full = (w.gray == {~w.rgS2[AW:AW-1], w.rgS2[AW-2:0]});
  assign empty = (r.gray == r.wgS2);
  assign wrReady = ~full;
  assign rdValid = ~empty;
  // read straight from storage: the slot is stable while the pointers say it is filled
  assign rdData = w.mem[r.bin[AW-1:0]];

  always_comb begin
    wn = w;
    wBinNxt = w.bin;
    wn.rgS1 = r.gray;
    wn.rgS2 = w.rgS1;
    if (wrValid & ~full) begin
      wn.mem[w.bin[AW-1:0]] = wrData;
      wBinNxt = (AW+1)'(w.bin + 1'b1);
    end
    wn.bin = wBinNxt;
    wn.gray = wBinNxt ^ (wBinNxt >> 1);
  end

  always_ff @(posedge wrClk or negedge reset_n) begin
    if (!reset_n) begin
      w <= '0;
    end else begin
      w <= wn;
    end
  end

  always_comb begin
    rn = r;
    rBinNxt = r.bin;
    rn.wgS1 = w.gray;
    rn.wgS2 = r.wgS1;
    if (rdReady & ~empty) begin
      rBinNxt = (AW+1)'(r.bin + 1'b1);
    end
    rn.bin = rBinNxt;
    rn.gray = rBinNxt ^ (rBinNxt >> 1);
  end

  always_ff @(posedge rdClk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= rn;
    end
  end

  chk_full_holds_ptr: assert property (@(posedge wrClk)
    disable iff (!reset_n) wrValid |=> w.bin == (AW+1)'($past(w.bin) + !$past(full)))
    else $error("fifo write pointer not stepping with accepted writes");
  chk_empty_holds_ptr: assert property (@(posedge rdClk)
    disable iff (!reset_n) rdReady |=> r.bin == (AW+1)'($past(r.bin) + !$past(empty)))
    else $error("fifo read pointer not stepping with accepted reads");
endmodule

module serial_video_link_receiver
  import svl_rx_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic serialBitClk,
  input wire logic serialInputPair,
  input wire logic powerDownBar,
  input wire logic outputLaneEnable,
  input wire logic outputSleepStateSelect,
  input wire logic lowFrequencySelect,
  output logic [LANES-1:0] outputDataLanes,
  output logic outputClockLane,
  output logic outputLanesOe,
  output logic [2:0] oversampledLowRateBits,
  output logic linkLocked,
  output logic lowFrequencyBand
);
  typedef struct packed {
    logic [1:0] rxSync;
    logic [1:0] pdSync;
    logic [FRAME_BITS-1:0] shift;
    logic [4:0] bitCnt;
    logic [2:0] goodCnt;
    linkState_t state;
    logic locked;
    logic [PIX_W-1:0] word;
    logic wordValid;
  } linkRegs_t;
  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
    logic cfgLoaded;
    logic lfMode;
    logic sleepSel;
    logic busy;
    logic half;
    logic [2:0] bitIdx;
    logic [PIX_LAST:0] pixel;
    logic [LANES-1:0] lanes;
    logic clkLane;
    logic oe;
    logic [2:0] osBits;
    logic locked;
    logic lfBand;
  } coreRegs_t;
  linkRegs_t l, ln;
  coreRegs_t c, cn;
  logic frameEnd;
  logic frameOk;
  logic emit;
  logic [PIX_W-1:0] payload;
  logic wrReady;
  logic rdValid;
  logic rdReady;
  logic [PIX_W-1:0] rdData;
  logic pdOn;
  logic lockNow;
  logic step;
  logic lastStep;
  logic load;
  logic [LANES-1:0] laneBit;

  // ---- link domain: frame hunt and decode
  always_comb begin
    ln = l;
    emit = 1'b0;
    ln.rxSync = {l.rxSync[0], serialInputPair};
    ln.pdSync = {l.pdSync[0], powerDownBar};
    ln.shift = {l.shift[FRAME_BITS-2:0], l.rxSync[1]};
    frameEnd = (l.bitCnt == FRAME_LAST);
    // embedded clock edge: start high, pad and stop low
    frameOk = ln.shift[POS_START] & ~ln.shift[POS_PAD] & ~ln.shift[POS_STOP];
    payload = ln.shift[POS_DATA_HI:POS_DATA_LO];
    if (l.wordValid & wrReady) begin
      ln.wordValid = 1'b0;
    end
    if (!l.pdSync[1]) begin
      ln.state = ST_HUNT;
      ln.bitCnt = FRAME_LAST;
      ln.goodCnt = 3'h0;
      ln.wordValid = 1'b0;
    end else if (!frameEnd) begin
      ln.bitCnt = 5'(l.bitCnt + 5'h1);
    end else begin
      ln.bitCnt = 5'h0;
      case (l.state)
        // hunting tests every bit position until a boundary fits
        ST_HUNT: begin
          if (frameOk) begin
            ln.state = ST_VERIFY;
            ln.goodCnt = 3'h1;
          end else begin
            ln.bitCnt = FRAME_LAST;
          end
        end
        ST_VERIFY: begin
          if (!frameOk) begin
            ln.state = ST_HUNT;
            ln.goodCnt = 3'h0;
            ln.bitCnt = FRAME_LAST;
          end else if (l.goodCnt == LOCK_LAST) begin
            ln.state = ST_LOCKED;
          end else begin
            ln.goodCnt = 3'(l.goodCnt + 3'h1);
          end
        end
        ST_LOCKED: begin
          if (!frameOk) begin
            ln.state = ST_HUNT;
            ln.goodCnt = 3'h0;
            ln.bitCnt = FRAME_LAST;
          end else begin
            // a word the fifo has not taken is overwritten, never reordered
            emit = 1'b1;
            ln.word = ln.shift[POS_INV] ? ~payload : payload;
            ln.wordValid = 1'b1;
          end
        end
        default: begin
          ln.state = ST_HUNT;
        end
      endcase
    end
    ln.locked = (ln.state == ST_LOCKED);
  end

  always_ff @(posedge serialBitClk or negedge reset_n) begin
    if (!reset_n) begin
      l <= '{state: ST_HUNT, bitCnt: FRAME_LAST, default: '0};
    end else begin
      l <= ln;
    end
  end

  // word crossing into the core domain
  svl_word_fifo #(
    .WIDTH(PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .reset_n(reset_n),
    .wrClk(serialBitClk),
    .wrValid(l.wordValid),
    .wrReady(wrReady),
    .wrData(l.word),
    .rdClk(core_clk),
    .rdValid(rdValid),
    .rdReady(rdReady),
    .rdData(rdData)
  );

  // ---- core domain: lane serialiser
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    assign laneBit[k] = c.pixel[LANE_BITS*k + 32'(LANE_LAST - c.bitIdx)];
  end

  always_comb begin
    cn = c;
    load = 1'b0;
    cn.s1 = {outputSleepStateSelect, lowFrequencySelect, outputLaneEnable,
             powerDownBar, l.locked};
    cn.s2 = c.s1;
    pdOn = c.s2[SY_PD];
    lockNow = pdOn & c.s2[SY_LOCK];
    // low band holds each lane bit for two core cycles
    step = c.busy & (~c.lfMode | c.half);
    lastStep = step & (c.bitIdx == LANE_LAST);
    rdReady = lockNow & (~c.busy | lastStep);
    if (c.busy & c.lfMode) begin
      cn.half = ~c.half;
    end
    if (step) begin
      cn.bitIdx = 3'(c.bitIdx + 3'h1);
    end
    if (lastStep) begin
      cn.busy = 1'b0;
      cn.bitIdx = 3'h0;
    end
    if (rdReady & rdValid) begin
      load = 1'b1;
      cn.busy = 1'b1;
      cn.half = 1'b0;
      cn.bitIdx = 3'h0;
      cn.pixel = rdData[PIX_LAST:0];
      cn.osBits = rdData[OS_HI:OS_LO];
    end
    if (!pdOn) begin
      cn.cfgLoaded = 1'b0;
      cn.lfMode = LF_RST;
      cn.sleepSel = OSS_RST;
      cn.busy = 1'b0;
      cn.half = 1'b0;
      cn.bitIdx = 3'h0;
    end else if (!c.cfgLoaded) begin
      cn.cfgLoaded = 1'b1;
      cn.lfMode = c.s2[SY_LF];
      cn.sleepSel = c.s2[SY_OSS];
    end
    if (!lockNow) begin
      cn.busy = 1'b0;
      // sleep select low clears the slow bits, high keeps their last value
      if (!c.sleepSel) begin
        cn.osBits = OS_RST;
      end
    end
    cn.lanes = (c.busy & lockNow) ? laneBit : LANE_IDLE;
    cn.clkLane = (c.busy & lockNow) & CLK_PATTERN[LANE_LAST - c.bitIdx];
    cn.oe = c.s2[SY_OE];
    cn.locked = lockNow;
    cn.lfBand = c.lfMode;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      c <= '0;
    end else begin
      c <= cn;
    end
  end

  assign outputDataLanes = c.lanes;
  assign outputClockLane = c.clkLane;
  assign outputLanesOe = c.oe;
  assign oversampledLowRateBits = c.osBits;
  assign linkLocked = c.locked;
  assign lowFrequencyBand = c.lfBand;

  chk_lock_needs_verify: assert property (
    @(posedge serialBitClk) disable iff (!reset_n)
    (l.state == ST_LOCKED) && !$past(l.state == ST_LOCKED) |-> $past(l.state == ST_VERIFY))
    else $error("lock taken without verify frames");
  chk_balance_decode: assert property (
    @(posedge serialBitClk) disable iff (!reset_n)
    emit |=> l.word == ($past(ln.shift[POS_INV]) ? ~$past(payload) : $past(payload)))
    else $error("payload inversion not undone");
  chk_flag_follows_lock: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    c.s2[SY_LOCK] && c.s2[SY_PD] |=> linkLocked)
    else $error("locked flag low while locked");
  chk_sleep_lanes: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !linkLocked |-> outputDataLanes == LANE_IDLE && !outputClockLane)
    else $error("lanes active while unlocked");
  chk_pd_resets_cfg: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !c.s2[SY_PD] |=> !c.cfgLoaded && !c.lfMode && !linkLocked)
    else $error("power-down did not reset configuration");
  chk_oe_from_pin: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !$past(!reset_n, 3) |-> outputLanesOe == $past(outputLaneEnable, 3))
    else $error("lane enable not following pin");
  chk_pixel_spacing: assert property (
    @(posedge core_clk) disable iff (!reset_n) load |=> !load [*6])
    else $error("pixel shorter than seven lane bits");
  chk_slow_bit_map: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    load |=> oversampledLowRateBits == $past(rdData[OS_HI:OS_LO]) || !linkLocked)
    else $error("slow bits not from word bits 23:21");
endmodule

/* File: svl_serializer_model.sv */
// upstream serializer model: endless 28-bit frames on the serial line
// assumes serialBitClk runs free while frames flow; idle frames carry slowBits only
`timescale 1ns/100ps

module svl_serializer_model
  import svl_rx_pkg::*;
(
  input wire logic serialBitClk,
  input wire logic [2:0] slowBits,
  input wire logic breakFrame,
  output logic serialInputPair
);
  logic [PIX_W-1:0] pend[$];
  logic [PIX_W-1:0] w;
  logic [FRAME_BITS-1:0] fr;
  logic inv = 1'b0;
  int pos = 0;

  task automatic send(input logic [PIX_W-1:0] word);
    pend.push_back(word);
  endtask

  initial serialInputPair = 1'b0;
  always begin
    @(posedge serialBitClk);
    #2;
    if (pos == 0) begin
      // filler carries the slow bits
      w = (pend.size() != 0) ? pend.pop_front() : {slowBits, 21'h0};
      // alternate the invert flag so both codings are seen
      inv = ~inv;
      // a set stop bit is the only fault this model makes
      fr = {1'b1, inv, inv ? ~w : w, 1'b0, breakFrame};
    end
    serialInputPair = fr[FRAME_BITS-1-pos];
    pos = (pos == FRAME_BITS-1) ? 0 : pos + 1;
  end
endmodule

/* File: tb_serial_video_link_receiver.sv */
// self-checking bench for the serial video link receiver
// assumes the serializer model feeds the line; lanes are decoded back into words
`timescale 1ns/100ps

module tb_serial_video_link_receiver;
  import svl_rx_pkg::*;
  logic core_clk, reset_n, serialBitClk, serialInputPair, powerDownBar;
  logic outputLaneEnable, outputSleepStateSelect, lowFrequencySelect;
  logic [LANES-1:0] outputDataLanes;
  logic outputClockLane, outputLanesOe, linkLocked, lowFrequencyBand, breakFrame, clkPrev;
  logic [2:0] oversampledLowRateBits, slowBits;
  logic [6:0] ln0, ln1, ln2, ck;
  logic [20:0] got[$];
  logic [20:0] exp[$];
  logic [20:0] pat[4] = '{21'h1fffff, 21'h155555, 21'h0aaaaa, 21'h000001};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0, ph = 0, sub = 0;

  serial_video_link_receiver dut (.core_clk(core_clk), .reset_n(reset_n),
    .serialBitClk(serialBitClk), .serialInputPair(serialInputPair),
    .powerDownBar(powerDownBar), .outputLaneEnable(outputLaneEnable),
    .outputSleepStateSelect(outputSleepStateSelect), .lowFrequencySelect(lowFrequencySelect),
    .outputDataLanes(outputDataLanes), .outputClockLane(outputClockLane),
    .outputLanesOe(outputLanesOe), .oversampledLowRateBits(oversampledLowRateBits),
    .linkLocked(linkLocked), .lowFrequencyBand(lowFrequencyBand));
  svl_serializer_model peer (.serialBitClk(serialBitClk), .slowBits(slowBits),
    .breakFrame(breakFrame), .serialInputPair(serialInputPair));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    serialBitClk = 1'b0;
    #7;
    forever #16 serialBitClk = ~serialBitClk;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // lane decoder; pixels never come back to back here; a cut pixel is dropped
  always @(negedge core_clk) begin
    if (linkLocked !== 1'b1) ph = 0;
    if (ph == 0 && outputClockLane === 1'b1 && clkPrev === 1'b0) begin
      ph = 1;
      sub = 0;
    end
    if (ph != 0 && sub == 0) begin
      ln0 = {ln0[5:0], outputDataLanes[0]};
      ln1 = {ln1[5:0], outputDataLanes[1]};
      ln2 = {ln2[5:0], outputDataLanes[2]};
      ck = {ck[5:0], outputClockLane};
      if (ph == LANE_BITS) begin
        check(24'(ck), 24'(CLK_PATTERN));
        if ({ln2, ln1, ln0} != 21'h0) got.push_back({ln2, ln1, ln0});
        ph = -1;
      end
      ph++;
    end
    if (ph != 0) sub = (lowFrequencySelect && sub == 0) ? 1 : 0;
    clkPrev = outputClockLane;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic waitLock(input logic v);
    int n;
    n = 0;
    while (linkLocked !== v && n < 600) begin
      tick(1);
      n++;
    end
    check(24'(linkLocked), 24'(v));
  endtask

  task automatic sendWords(input logic [2:0] os);
    int n;
    slowBits = os;
    // slow bits steady across the four words
    for (int i = 0; i < 4; i++) begin
      peer.send({os, pat[i]});
      exp.push_back(pat[i]);
    end
    n = 0;
    while (got.size() < 4 && n < 600) begin
      tick(1);
      n++;
    end
    check(24'(got.size()), 24'h4);
    while (exp.size() != 0 && got.size() != 0)
      check(24'(got.pop_front()), 24'(exp.pop_front()));
    check(24'(oversampledLowRateBits), 24'(os));
  endtask

  task automatic breakLink;
    breakFrame = 1'b1;
    tick(20);
    breakFrame = 1'b0;
    waitLock(1'b0);
    check(24'({outputDataLanes, outputClockLane}), 24'h0);
  endtask

  initial begin
    reset_n = 1'b0;
    powerDownBar = 1'b1;
    outputLaneEnable = 1'b1;
    outputSleepStateSelect = 1'b0;
    lowFrequencySelect = 1'b0;
    breakFrame = 1'b0;
    slowBits = 3'h5;
    clkPrev = 1'b0;
    tick(4);
    reset_n = 1'b1;
    // no training pattern: idle filler alone must bring lock
    waitLock(1'b1);
    check(24'(lowFrequencyBand), 24'h0);
    check(24'(outputLanesOe), 24'h1);
    sendWords(3'h5);
    breakLink();
    check(24'(oversampledLowRateBits), 24'h0);
    waitLock(1'b1);
    outputLaneEnable = 1'b0;
    tick(4);
    check(24'(outputLanesOe), 24'h0);
    outputLaneEnable = 1'b1;
    tick(4);
    check(24'(outputLanesOe), 24'h1);
    powerDownBar = 1'b0;
    tick(10);
    check(24'({linkLocked, outputDataLanes, outputClockLane}), 24'h0);
    check(24'({oversampledLowRateBits, lowFrequencyBand}), 24'h0);
    outputSleepStateSelect = 1'b1;
    lowFrequencySelect = 1'b1;
    tick(2);
    powerDownBar = 1'b1;
    waitLock(1'b1);
    check(24'(lowFrequencyBand), 24'h1);
    sendWords(3'h6);
    breakLink();
    // select high: slow bits hold while unlocked
    check(24'(oversampledLowRateBits), 24'h6);
    end_of_test();
  end
endmodule
